// >>> opsts_top.sv
// Contract
// - per-module stop code: tristate, low, high
// - low stop, differential: odd bits high
// - high stop, differential: odd bits low
// - tristate stop covers every bit
// - buffer shutdown disables its whole nibble
// - other nibbles keep replaying data
// - disabled until fault status is read
// - shared ninth buffer disables whole module
// - bits 0-3 nibbles, bit 4 module 0
// - bits 16-20 module 1, rest zero
// - one 32-bit word, flags combine
// - flags latched until read, cleared then
// - no fault reads as zero
// - status read invalidates pattern memory
// - missing aux supply shows as disabled
// - differential: even true, odd inverted
`timescale 1ns/1ps
`default_nettype none
module opsts_top (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic DIFF_MODE,
  input wire logic M0_REPLAY,
  input wire logic M1_REPLAY,
  input wire logic [opsts_pkg::N_BITS-1:0] M0_PATTERN,
  input wire logic [opsts_pkg::N_BITS-1:0] M1_PATTERN,
  input wire logic [opsts_pkg::N_BUF-1:0] M0_THERM_SD,
  input wire logic [opsts_pkg::N_BUF-1:0] M1_THERM_SD,
  input wire logic AUX_REQUIRED,
  input wire logic AUX_SUPPLY_OK,
  output logic [opsts_pkg::N_BITS-1:0] M0_DATA_OUT,
  output logic [opsts_pkg::N_BITS-1:0] M0_OE_N,
  output logic [opsts_pkg::N_BITS-1:0] M1_DATA_OUT,
  output logic [opsts_pkg::N_BITS-1:0] M1_OE_N,
  output logic PATTERN_INVALID,
  output logic IRQ
);
  import opsts_pkg::*;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] sync_s;
  logic [N_BUF-1:0] therm_s [N_MOD];
  logic aux_miss_s;

  opsts_sync #(.W(SYNC_W)) u_sync (
    .clk(REF_CLK),
    .rst(RST),
    // supply goes through as missing, so the cleared stages read as present after reset
    .async_in({!AUX_SUPPLY_OK, M1_THERM_SD, M0_THERM_SD}),
    .sync_out(sync_s)
  );

  assign therm_s[0] = sync_s[N_BUF-1:0];
  assign therm_s[1] = sync_s[2*N_BUF-1:N_BUF];
  assign aux_miss_s = sync_s[2*N_BUF];

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  logic [STOP_W-1:0] stop_q [N_MOD];
  logic [31:0] flt_q;
  logic [31:0] flt_d;
  logic [31:0] flt_set;
  logic [IRQ_W-1:0] irq_st_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic inval_q;
  logic irq_q;
  logic [29:0] widx;
  logic setup;
  logic fire;
  logic rd_flt;
  logic wr_fire;
  logic mapped;

  assign widx = PADDR[31:2];
  assign setup = PSEL && !PENABLE;
  assign fire = PSEL && PENABLE && pready_q;
  assign rd_flt = fire && !PWRITE && (widx == IDX_FAULT_STATUS);
  assign wr_fire = fire && PWRITE && !pslverr_q;
  assign mapped = (widx == IDX_FAULT_STATUS) || (widx == IDX_M0_STOP) || (widx == IDX_M1_STOP) ||
                  (widx == IDX_IRQ_STATUS) || (widx == IDX_IRQ_MASK);

  // read data is captured in the setup cycle so the answer comes from a flop
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      prdata_q <= ZERO_WORD;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      pready_q <= 1'b1;
      pslverr_q <= !mapped;
      prdata_q <= ZERO_WORD;
      if (!PWRITE) begin
        case (widx)
          IDX_FAULT_STATUS: prdata_q <= flt_q;
          IDX_M0_STOP: prdata_q <= {{(32-STOP_W){1'b0}}, stop_q[0]};
          IDX_M1_STOP: prdata_q <= {{(32-STOP_W){1'b0}}, stop_q[1]};
          IDX_IRQ_STATUS: prdata_q <= {{(32-IRQ_W){1'b0}}, irq_st_q};
          IDX_IRQ_MASK: prdata_q <= {{(32-IRQ_W){1'b0}}, irq_mask_q};
          default: prdata_q <= ZERO_WORD;
        endcase
      end
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      stop_q[0] <= STOP_TRI;
      stop_q[1] <= STOP_TRI;
    end else if (wr_fire) begin
      if (widx == IDX_M0_STOP) begin
        stop_q[0] <= PWDATA[STOP_W-1:0];
      end
      if (widx == IDX_M1_STOP) begin
        stop_q[1] <= PWDATA[STOP_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // fault status word
  // ----------------------------------------------------------------
  genvar m;
  genvar b;
  generate
    for (m = 0; m < N_MOD; m++) begin : g_set
      for (b = 0; b < N_NIB; b++) begin : g_nib
        assign flt_set[m*FLT_MOD_STRIDE+b] = therm_s[m][2*b] || therm_s[m][2*b+1];
      end
      assign flt_set[m*FLT_MOD_STRIDE+FLT_ALL_POS] = therm_s[m][BUF_ALL] || (AUX_REQUIRED && aux_miss_s);
      assign flt_set[m*FLT_MOD_STRIDE+FLT_MOD_STRIDE-1:m*FLT_MOD_STRIDE+FLT_ALL_POS+1] = '0;
    end
  endgenerate

  // only the bits that were returned are cleared; a set in the same cycle wins
  assign flt_d = ((flt_q & ~(rd_flt ? prdata_q : ZERO_WORD)) | flt_set) & FLT_MASK;

  // latched: recovery alone never clears a flag
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      flt_q <= ZERO_WORD;
    end else begin
      flt_q <= flt_d;
    end
  end

  // each status read flags the pattern memory as stale
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      inval_q <= 1'b0;
    end else begin
      inval_q <= rd_flt;
    end
  end

  assign PATTERN_INVALID = inval_q;

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  logic [IRQ_W-1:0] irq_ev;
  logic [IRQ_W-1:0] irq_clr;

  assign irq_ev[IRQ_FAULT] = |(flt_set & ~flt_q);
  assign irq_ev[IRQ_INVAL] = rd_flt;
  assign irq_clr = (wr_fire && widx == IDX_IRQ_STATUS) ? PWDATA[IRQ_W-1:0] : IRQ_RST;

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      irq_st_q <= IRQ_RST;
    end else begin
      irq_st_q <= (irq_st_q & ~irq_clr) | irq_ev;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      irq_mask_q <= IRQ_RST;
    end else if (wr_fire && widx == IDX_IRQ_MASK) begin
      irq_mask_q <= PWDATA[IRQ_W-1:0];
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      // lags the status by one edge so the pin comes from a flop
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_st_q & irq_mask_q);
    end
  end

  assign IRQ = irq_q;

  // ----------------------------------------------------------------
  // output drivers
  // ----------------------------------------------------------------
  wire [N_BITS-1:0] pat [N_MOD];
  wire [N_BITS-1:0] val_d [N_MOD];
  wire [N_BITS-1:0] oen_d [N_MOD];
  wire [N_MOD-1:0] replay;
  opsts_drv_t drv [N_MOD];

  assign pat[0] = M0_PATTERN;
  assign pat[1] = M1_PATTERN;
  assign replay = {M1_REPLAY, M0_REPLAY};

  generate
    for (m = 0; m < N_MOD; m++) begin : g_mod
      // any other code falls back to tristate
      always_comb begin
        case (stop_q[m])
          STOP_LOW: drv[m] = OPSTS_DRV_LOW;
          STOP_HIGH: drv[m] = OPSTS_DRV_HIGH;
          default: drv[m] = OPSTS_DRV_TRI;
        endcase
      end
      for (b = 0; b < N_BITS; b++) begin : g_bit
        localparam bit ODD = (b % 2) == 1;
        wire dis;
        wire inv;
        // only the flagged nibble or module goes dark
        assign dis = flt_q[m*FLT_MOD_STRIDE+b/NIB_W] || flt_q[m*FLT_MOD_STRIDE+FLT_ALL_POS];
        assign inv = DIFF_MODE && ODD;
        // odd bit replays inverse of its even partner
        // stop level swaps on the odd bits
        assign val_d[m][b] = replay[m] ? (inv ? !pat[m][b-(ODD ? 1 : 0)] : pat[m][b]) :
                             ((drv[m] == OPSTS_DRV_HIGH) != inv);
        assign oen_d[m][b] = dis || (!replay[m] && drv[m] == OPSTS_DRV_TRI);
      end
    end
  endgenerate

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      M0_DATA_OUT <= '0;
      M1_DATA_OUT <= '0;
      M0_OE_N <= '1;
      M1_OE_N <= '1;
    end else begin
      M0_DATA_OUT <= val_d[0];
      M1_DATA_OUT <= val_d[1];
      M0_OE_N <= oen_d[0];
      M1_OE_N <= oen_d[1];
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  a_flag_sticky: assert property (!rd_flt |=> (($past(flt_q) & ~flt_q) == 32'h00000000))
    else $error("fault flag dropped without a status read");
  a_read_clears: assert property ((rd_flt && flt_set == 32'h00000000) |=> (flt_q & $past(prdata_q)) == 32'h00000000)
    else $error("status read did not clear returned flags");
  a_nib_dark: assert property (therm_s[0][2] |=> flt_q[1] ##1 (M0_OE_N[7:4] == 4'hf))
    else $error("nibble not disabled after buffer shutdown");
  a_other_nib: assert property ((M0_REPLAY && flt_q[1] && flt_q[4:0] == 5'h02) |=> M0_OE_N[3:0] == 4'h0)
    else $error("healthy nibble stopped replaying");
  a_module_dark: assert property (therm_s[1][8] |=> flt_q[20] ##1 (M1_OE_N == 16'hffff))
    else $error("module not disabled after shared buffer shutdown");
  a_reserved_zero: assert property ((flt_q & ~FLT_MASK) == 32'h00000000)
    else $error("reserved fault bit set");
  a_stop_tri: assert property ((!M0_REPLAY && stop_q[0] != STOP_LOW && stop_q[0] != STOP_HIGH) |=> M0_OE_N == 16'hffff)
    else $error("tristate stop still driving");
  a_diff_low: assert property ((!M0_REPLAY && DIFF_MODE && stop_q[0] == STOP_LOW && flt_q[4:0] == 5'h00)
                               |=> (M0_DATA_OUT == 16'haaaa && M0_OE_N == 16'h0000))
    else $error("low stop differential pattern wrong");
  a_diff_high: assert property ((!M1_REPLAY && DIFF_MODE && stop_q[1] == STOP_HIGH && flt_q[20:16] == 5'h00)
                                |=> (M1_DATA_OUT == 16'h5555 && M1_OE_N == 16'h0000))
    else $error("high stop differential pattern wrong");
  a_diff_pair: assert property ((M0_REPLAY && DIFF_MODE) |=> M0_DATA_OUT[1] != $past(M0_PATTERN[0]))
    else $error("odd bit is not the inverse of its pair");
  a_aux_missing: assert property ((AUX_REQUIRED && aux_miss_s) |=> (flt_q[4] && flt_q[20]))
    else $error("missing supply not reported");
  a_inval_pulse: assert property (rd_flt |=> PATTERN_INVALID ##1 !PATTERN_INVALID)
    else $error("pattern invalidation not signalled");

  // bus side, fault latching, both modules and invalidation
  a_stop_write: assert property ((wr_fire && widx == IDX_M0_STOP) |=> stop_q[0] == $past(PWDATA[STOP_W-1:0]))
    else $error("stop code write not stored");
  a_status_word: assert property ((setup && !PWRITE && widx == IDX_FAULT_STATUS) |=> PRDATA == $past(flt_q))
    else $error("status word not returned whole");
  a_clean_zero: assert property ((setup && !PWRITE && widx == IDX_FAULT_STATUS && flt_q == ZERO_WORD)
                                 |=> PRDATA == ZERO_WORD)
    else $error("clean status word not zero");
  a_set_wins: assert property ((flt_set != ZERO_WORD) |=> (flt_q & $past(flt_set)) == $past(flt_set))
    else $error("fault event lost");
  a_replay_on: assert property ((M1_REPLAY && flt_q[20:16] == 5'h00) |=> M1_OE_N == 16'h0000)
    else $error("healthy module stopped replaying");
  a_even_true: assert property (M0_REPLAY |=> M0_DATA_OUT[0] == $past(M0_PATTERN[0]))
    else $error("even bit does not carry the true signal");
  a_code_other: assert property ((!M1_REPLAY && stop_q[1] != STOP_LOW && stop_q[1] != STOP_HIGH)
                                 |=> M1_OE_N == 16'hffff)
    else $error("unknown stop code still driving");
  a_all_m0: assert property (flt_q[FLT_ALL_POS] |=> M0_OE_N == 16'hffff)
    else $error("module 0 not fully disabled");
  a_all_m1: assert property (flt_q[FLT_MOD_STRIDE+FLT_ALL_POS] |=> M1_OE_N == 16'hffff)
    else $error("module 1 not fully disabled");
  a_inval_idle: assert property (!rd_flt |=> !PATTERN_INVALID)
    else $error("pattern invalidated without a status read");

  // ----------------------------------------------------------------
  // cover properties
  // ----------------------------------------------------------------
  c_nib_fault: cover property (therm_s[0][0] ##1 flt_q[0] ##[1:20] rd_flt);
  c_status_read: cover property (rd_flt && prdata_q != 32'h00000000);
  c_diff_stop: cover property (!M0_REPLAY && DIFF_MODE && stop_q[0] == STOP_HIGH);
  c_module_dark: cover property (therm_s[1][BUF_ALL] ##1 flt_q[FLT_MOD_STRIDE+FLT_ALL_POS]);
  c_aux_missing: cover property (AUX_REQUIRED && aux_miss_s);
endmodule
`default_nettype wire

// >>> opsts_pkg.sv
package opsts_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [29:0] IDX_FAULT_STATUS = 30'h000324b0;
  localparam logic [29:0] IDX_M1_STOP = 30'h000324ba;
  localparam logic [29:0] IDX_M0_STOP = 30'h000324c4;
  localparam logic [29:0] IDX_IRQ_STATUS = 30'h000324ce;
  localparam logic [29:0] IDX_IRQ_MASK = 30'h000324cf;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int N_MOD = 2;
  localparam int N_BITS = 16;
  localparam int N_NIB = 4;
  localparam int N_BUF = 9;
  localparam int NIB_W = 4;
  localparam int BUF_ALL = 8;
  localparam int FLT_MOD_STRIDE = 16;
  localparam int FLT_ALL_POS = 4;
  localparam logic [31:0] FLT_MASK = 32'h001f001f;
  localparam int STOP_W = 2;
  localparam int IRQ_W = 2;
  localparam int IRQ_FAULT = 0;
  localparam int IRQ_INVAL = 1;
  localparam int SYNC_W = 2 * N_BUF + 1;

  // ----------------------------------------------------------------
  // reset values and codes
  // ----------------------------------------------------------------
  localparam logic [STOP_W-1:0] STOP_TRI = 2'h0;
  localparam logic [STOP_W-1:0] STOP_LOW = 2'h1;
  localparam logic [STOP_W-1:0] STOP_HIGH = 2'h2;
  localparam logic [31:0] ZERO_WORD = 32'h00000000;
  localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;

  typedef enum logic [1:0] {OPSTS_DRV_TRI, OPSTS_DRV_LOW, OPSTS_DRV_HIGH} opsts_drv_t;

endpackage

// >>> opsts_sync.sv
`timescale 1ns/1ps
`default_nettype none
module opsts_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a bit is only taken once two settled stages agree, filtering one-cycle glitches
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk) begin
        if (rst) begin
          sync_out[i] <= 1'b0;
        end else if (s2_q[i] == s3_q[i]) begin
          sync_out[i] <= s3_q[i];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// >>> opsts_buf_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// line buffer thermal model
// ----------------------------------------------------------------
module opsts_buf_model #(
  parameter int W = 18
) (
  input wire logic clk,
  input wire logic [W-1:0] hot,
  output logic [W-1:0] sd
);
  // a buffer only reports shutdown while it is overheated; the latching
  // must therefore come from the device, not from this pin
  always_ff @(posedge clk) begin
    sd <= hot;
  end
endmodule
`default_nettype wire

// >>> opsts_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module opsts_top_tb;
  import opsts_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam logic [31:0] A_FLT = {IDX_FAULT_STATUS, 2'h0};
  localparam logic [31:0] A_M0 = {IDX_M0_STOP, 2'h0};
  localparam logic [31:0] A_M1 = {IDX_M1_STOP, 2'h0};
  localparam logic [31:0] A_IS = {IDX_IRQ_STATUS, 2'h0};
  localparam logic [31:0] A_IM = {IDX_IRQ_MASK, 2'h0};
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, pready, pslverr, e;
  logic [31:0] paddr = 0, pwdata = 0, prdata, r, rnd = 32'hdbbaee35;
  logic diff = 0, rp0 = 0, rp1 = 0, aux_req = 0, aux_ok = 1, pinv, irq;
  logic [15:0] pat0 = 0, pat1 = 0, d0, d1, oe0, oe1;
  logic [17:0] hot = 0, sd;
  logic [3:0] dis0 = 0, dis1 = 0;
  logic [1:0] c0 = 0, c1 = 0;
  int miscompares = 0, cmp_count = 0, i, n;
  always #5 clk = ~clk;
  opsts_buf_model #(.W(18)) BUF (.clk(clk), .hot(hot), .sd(sd));
  opsts_top DUT (.REF_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .DIFF_MODE(diff), .M0_REPLAY(rp0), .M1_REPLAY(rp1), .M0_PATTERN(pat0), .M1_PATTERN(pat1),
    .M0_THERM_SD(sd[8:0]), .M1_THERM_SD(sd[17:9]), .AUX_REQUIRED(aux_req),
    .AUX_SUPPLY_OK(aux_ok), .M0_DATA_OUT(d0), .M0_OE_N(oe0), .M1_DATA_OUT(d1),
    .M1_OE_N(oe1), .PATTERN_INVALID(pinv), .IRQ(irq));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // data is masked where the pin floats, its level is meaningless there
  function automatic logic [31:0] exp_out(input logic [1:0] c, input logic df, rp,
      input logic [15:0] pat, input logic [3:0] dis);
    logic [15:0] d, oe;
    d = rp ? pat : {16{c == STOP_HIGH}};
    oe = (rp || c == STOP_LOW || c == STOP_HIGH) ? 16'h0000 : 16'hffff;
    for (int k = 0; k < 16; k += 2) begin
      if (df) d[k+1] = ~d[k];
      if (dis[k/4]) oe[k+:2] = 2'h3;
    end
    return {oe, d & ~oe};
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task cmp_pins;
    chk({oe0, d0 & ~oe0}, exp_out(c0, diff, rp0, pat0, dis0));
    chk({oe1, d1 & ~oe1}, exp_out(c1, diff, rp1, pat1, dis1));
  endtask
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    pen <= 0;
  endtask
  task wait_n(input int k);
    repeat (k) @(posedge clk);
  endtask
  task test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    wait_n(20000);
    miscompares++;
    test_done;
  end
  initial begin
    wait_n(4);
    rst <= 0;
    apb(0, A_FLT, 0);
    chk(r, ZERO_WORD);
    cmp_pins;
    $display("reset test done");
    for (i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      diff <= i[2];
      c0 = i[1:0];
      c1 = 2'h3 - i[1:0];
      apb(1, A_M0, {rnd[31:2], c0});
      apb(1, A_M1, {rnd[31:2], c1});
      apb(0, A_M0, 0);
      chk(r, {30'h0, c0});
      wait_n(2);
      cmp_pins;
    end
    apb(1, A_IM + 32'h4, rnd);
    chk({31'h0, e}, 32'h1);
    $display("stop state test done");
    rnd = lfsr(rnd);
    {diff, pat0, pat1} <= {1'b1, rnd[31:16], rnd[15:0]};
    rp0 <= 1;
    rp1 <= 1;
    wait_n(3);
    cmp_pins;
    apb(1, A_IM, 32'h1);
    n = rnd[2:1];
    hot <= 18'h1 << (2 * n + rnd[3]);
    dis0 = 4'h1 << n;
    wait_n(10);
    cmp_pins;
    chk({31'h0, irq}, 32'h1);
    hot <= 0;
    wait_n(10);
    cmp_pins;
    apb(0, A_FLT, 0);
    chk(r, {28'h0, dis0});
    @(posedge clk);
    chk({31'h0, pinv}, 32'h1);
    rnd = lfsr(rnd);
    pat0 <= rnd[15:0];
    pat1 <= rnd[31:16];
    dis0 = 0;
    wait_n(3);
    cmp_pins;
    apb(0, A_FLT, 0);
    chk(r, ZERO_WORD);
    apb(1, A_IS, 32'h3);
    wait_n(3);
    chk({31'h0, irq}, 32'h0);
    apb(0, A_IS, 0);
    chk(r, ZERO_WORD);
    $display("nibble fault test done");
    hot <= 18'h20004;
    dis0 = 4'h2;
    dis1 = 4'hf;
    wait_n(10);
    cmp_pins;
    hot <= 0;
    wait_n(10);
    apb(0, A_FLT, 0);
    chk(r, 32'h00100002);
    dis0 = 4'hf;
    dis1 = 4'hf;
    aux_req <= 1;
    aux_ok <= 0;
    wait_n(10);
    cmp_pins;
    apb(0, A_FLT, 0);
    chk(r, 32'h00100010);
    aux_ok <= 1;
    wait_n(10);
    apb(0, A_FLT, 0);
    apb(0, A_FLT, 0);
    chk(r, ZERO_WORD);
    dis0 = 0;
    dis1 = 0;
    wait_n(3);
    cmp_pins;
    $display("group fault test done");
    test_done;
  end
endmodule
`default_nettype wire
